// file: fsam_pkg.sv
// Package: command codes, field masks, reset values and carrier types for fault status logic
`default_nettype none
package fsam_pkg;

	// Command codes on the management link
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
	localparam logic [7:0] CMD_CLEAR_PEAKS  = 8'hE3;
	localparam logic [7:0] CMD_SUM_BYTE     = 8'h78;
	localparam logic [7:0] CMD_SUM_WORD     = 8'h79;
	localparam logic [7:0] CMD_VOUT         = 8'h7A;
	localparam logic [7:0] CMD_IOUT         = 8'h7B;
	localparam logic [7:0] CMD_INPUT        = 8'h7C;
	localparam logic [7:0] CMD_TEMP         = 8'h7D;
	localparam logic [7:0] CMD_CML          = 8'h7E;
	localparam logic [7:0] CMD_VENDOR       = 8'h80;

	// Summary byte writable bits (busy and none-of-the-above)
	localparam logic [7:0] SUM_W1C_BITS     = 8'h81;
	// Input byte: bits that latch and may alert; bit 3 is live only
	localparam logic [7:0] INP_LATCH_BITS   = 8'hA2;
	localparam int         INP_OFF_BIT      = 3;

	// Mask reset values
	localparam logic [7:0] MASK_RST_ZERO    = 8'h00;
	localparam logic [7:0] MASK_RST_VENDOR  = 8'h11;

	// Clear-all must complete inside this time; longest time rounds down
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLR_TIME_NS   = 10000;
	localparam int CLR_MAX_CYC   = CLR_TIME_NS / CLK_PERIOD_NS;

	// Request kinds from the link engine
	typedef enum logic [2:0] {
		K_READ  = 3'b000,
		K_WRITE = 3'b001,
		K_SEND  = 3'b011,
		K_MASKW = 3'b010,
		K_MASKR = 3'b110
	} fsam_kind_type;

	// Live conditions of one channel
	typedef struct packed {
		logic [6:0] vout;
		logic       iout_oc;
		logic       iout_ocw;
		logic       temp_ot;
		logic       temp_otw;
		logic       temp_ut;
		logic       out_on;
		logic       pgood;
		logic       busy;
		logic [7:0] vendor;
	} fsam_chan_type;

	// All live conditions
	typedef struct packed {
		fsam_chan_type [1:0] ch;
		logic                in_ov;
		logic                in_uvw;
		logic                in_off;
		logic                in_ocw;
		logic [7:0]          cml;
	} fsam_cond_type;

	// One request from the link engine
	typedef struct packed {
		logic [7:0]    cmd;
		fsam_kind_type kind;
		logic [15:0]   data;
		logic          page;
	} fsam_req_type;

	// Core domain state
	typedef struct packed {
		fsam_cond_type   in_s1;
		fsam_cond_type   in_s2;
		logic            req_s1;
		logic            req_s2;
		logic            req_s3;
		logic            ack_tgl;
		logic [15:0]     rsp;
		logic [1:0][7:0] vout;
		logic [1:0][7:0] iout;
		logic [1:0][7:0] temp;
		logic [1:0][7:0] mvout;
		logic [1:0][7:0] miout;
		logic [1:0][7:0] mtemp;
		logic [1:0][7:0] mmfr;
		logic [7:0]      inp;
		logic [7:0]      minp;
		logic [7:0]      mcml;
		logic [1:0]      busy;
		logic [1:0]      nota;
		logic            alert;
		logic            peak_clr;
		logic            cml_inv;
	} fsam_core_type;

	// Link domain state
	typedef struct packed {
		fsam_req_type req;
		logic         req_tgl;
		logic         ack_s1;
		logic         ack_s2;
		logic         ack_s3;
		logic         busy;
		logic         rsp_valid;
		logic [15:0]  rsp;
	} fsam_link_type;

	localparam fsam_core_type CORE_RST = '{mmfr: {2{MASK_RST_VENDOR}}, default: '0};
	localparam fsam_link_type LINK_RST = '{req: '{kind: K_READ, default: '0}, default: '0};

endpackage
`default_nettype wire

// file: fsam_top.sv
// Fault status registers, alert masks and alert line for a dual-channel controller
// What this block does
// - Masked status bits still latch but never drive the alert line.
// - Mask write carries target code in byte one, bit-aligned mask in byte two.
// - Mask read names a target code and returns that register's mask byte.
// - No masks for summary byte, summary word, common vendor or pad registers.
// - Unsupported target code in mask access raises the invalid-data flag.
// - Masks reset to zero except vendor-specific mask, which resets to 0x11.
// - Clear-peaks and soft-reset commands both clear stored peak telemetry.
// - Summary byte: busy, off, VOUT OV, IOUT OC, zero, temp, comms, other.
// - Off bit set whenever channel delivers no output power, for any reason.
// - Summary bits 7 and 0 clear on write of one; bit 7 may alert, bit 0 never drives the alert line.
// - Summary byte read equals low byte of summary word.
// - Word high byte: vout, iout, input, vendor, not power-good, zeros.
// - Any high-byte bit set also sets none-of-the-above bit 0.
// - Voltage byte: OV fault, OV warn, UV warn, UV fault, max, on/off timeouts.
// - Writing one clears a status bit; writing zero leaves it.
// - Every supported voltage, current and input fault alerts unless masked.
// - Current byte: OC fault bit 7, OC warning bit 5, others zero.
// - Input byte: OV fault 7, UV warn 5, off for low input 3, OC warn 1.
// - Input bit 3 follows live condition, never latches, never alerts.
// - Temperature byte per page: OT fault 7, OT warn 6, UT fault 4.
// - Clear-all clears every status bit except summary bit 0 when high-byte bits were latched, and releases alert within 10us.
// - A condition still present after clearing sets its bit again.
// - Invalid-data flag is bit 6 of the communication status register.
`default_nettype none
module fsam_top
	import fsam_pkg::*;
#(
	parameter logic [7:0] SOFT_RESET_CODE = 8'hFD
) (
	// Core clock and reset
	input  wire logic          REF_CLK_I,
	input  wire logic          RESET_I,
	// Link side request and response
	input  wire logic          LINK_CLK_I,
	input  wire logic          CMD_VALID_I,
	input  wire fsam_req_type  CMD_I,
	output logic               CMD_READY_O,
	output logic               RSP_VALID_O,
	output logic [15:0]        RSP_DATA_O,
	// Live fault conditions from pins and monitors
	input  wire fsam_cond_type STAT_I,
	// Alert line and side effects
	output logic               ALERT_N_O,
	output logic               CML_INVALID_O,
	output logic               CLEAR_PEAKS_O
);

	// Release bound for the clear-all check, far inside the allowed clear time.
	// A tight bound catches a slow release path early.
	localparam int CLR_BOUND = 8;

	fsam_core_type   st_ff;
	fsam_core_type   nxt_st;
	fsam_link_type   lk_ff;
	fsam_link_type   nxt_lk;
	logic [1:0][15:0] sword;
	logic [7:0]       inp_view;
	logic             go;
	logic             alert_any;
	logic             any_cond;

	// Summary word per channel, built from latched and live state
	for (genvar c = 0; c < 2; c++) begin : g_sum
		assign sword[c] = {
			|st_ff.vout[c],
			|st_ff.iout[c],
			|st_ff.inp,
			|st_ff.in_s2.ch[c].vendor,
			~st_ff.in_s2.ch[c].pgood,
			3'b000,
			st_ff.busy[c],
			~st_ff.in_s2.ch[c].out_on,
			st_ff.vout[c][7],
			st_ff.iout[c][7],
			1'b0,
			|st_ff.temp[c],
			|st_ff.in_s2.cml,
			st_ff.nota[c]
		};
	end

	// Input byte as read: latched bits plus the live low-input bit
	assign inp_view = st_ff.inp | {4'h0, st_ff.in_s2.in_off, 3'b000};
	assign go       = st_ff.req_s2 != st_ff.req_s3;

	// Any unmasked alert-capable source, both pages
	always_comb begin
		alert_any = (|(st_ff.inp & INP_LATCH_BITS & ~st_ff.minp)) |
			(|(st_ff.in_s2.cml & ~st_ff.mcml));
		any_cond = (|st_ff.in_s2.cml) | st_ff.in_s2.in_ov | st_ff.in_s2.in_uvw |
			st_ff.in_s2.in_ocw;
		for (int c = 0; c < 2; c++) begin
			alert_any = alert_any | (|(st_ff.vout[c] & ~st_ff.mvout[c])) |
				(|(st_ff.iout[c] & ~st_ff.miout[c])) |
				(|(st_ff.temp[c] & ~st_ff.mtemp[c])) |
				(|(st_ff.in_s2.ch[c].vendor & ~st_ff.mmfr[c])) |
				st_ff.busy[c];
			any_cond = any_cond | (|st_ff.in_s2.ch[c].vout) | st_ff.in_s2.ch[c].iout_oc |
				st_ff.in_s2.ch[c].iout_ocw | st_ff.in_s2.ch[c].temp_ot |
				st_ff.in_s2.ch[c].temp_otw | st_ff.in_s2.ch[c].temp_ut |
				(|st_ff.in_s2.ch[c].vendor) | st_ff.in_s2.ch[c].busy |
				~st_ff.in_s2.ch[c].pgood;
		end
	end

	// Core next state: sync, execute one request, latch conditions
	always_comb begin
		fsam_req_type r;
		logic         pg;
		logic         clr_all;
		logic [7:0]   wdat;
		logic [7:0]   cv;
		logic [7:0]   ci;
		logic [7:0]   ct;
		logic [7:0]   clr_v;
		logic [7:0]   clr_i;
		logic [7:0]   clr_t;
		logic [7:0]   clr_s;
		logic [7:0]   clr_in;
		logic [15:0]  rd;
		r       = lk_ff.req;
		pg      = r.page;
		clr_all = 1'b0;
		wdat    = r.data[7:0];
		cv      = 8'h00;
		ci      = 8'h00;
		ct      = 8'h00;
		clr_v   = 8'h00;
		clr_i   = 8'h00;
		clr_t   = 8'h00;
		clr_s   = 8'h00;
		clr_in  = 8'h00;
		rd      = 16'h0000;
		nxt_st  = st_ff;
		// Two-stage sync of pins and request toggle
		nxt_st.in_s1    = STAT_I;
		nxt_st.in_s2    = st_ff.in_s1;
		nxt_st.req_s1   = lk_ff.req_tgl;
		nxt_st.req_s2   = st_ff.req_s1;
		nxt_st.req_s3   = st_ff.req_s2;
		nxt_st.peak_clr = 1'b0;
		nxt_st.cml_inv  = 1'b0;
		if (go) begin
			nxt_st.ack_tgl = ~st_ff.ack_tgl;
			case (r.kind)
				K_SEND: begin
					clr_all = r.cmd == CMD_CLEAR_FAULTS;
					nxt_st.peak_clr = (r.cmd == CMD_CLEAR_PEAKS) ||
						(r.cmd == SOFT_RESET_CODE);
				end
				K_WRITE: begin
					case (r.cmd)
						CMD_SUM_BYTE: clr_s  = wdat & SUM_W1C_BITS;
						CMD_SUM_WORD: clr_s  = wdat & SUM_W1C_BITS;
						CMD_VOUT:     clr_v  = wdat;
						CMD_IOUT:     clr_i  = wdat;
						CMD_TEMP:     clr_t  = wdat;
						CMD_INPUT:    clr_in = wdat;
						default:      clr_v  = 8'h00;
					endcase
				end
				K_READ: begin
					case (r.cmd)
						CMD_SUM_BYTE: rd = {8'h00, sword[pg][7:0]};
						CMD_SUM_WORD: rd = sword[pg];
						CMD_VOUT:     rd = {8'h00, st_ff.vout[pg]};
						CMD_IOUT:     rd = {8'h00, st_ff.iout[pg]};
						CMD_TEMP:     rd = {8'h00, st_ff.temp[pg]};
						CMD_INPUT:    rd = {8'h00, inp_view};
						default:      rd = 16'h0000;
					endcase
				end
				K_MASKW: begin
					// Target code in low byte, mask in high byte
					case (r.data[7:0])
						CMD_VOUT:   nxt_st.mvout[pg] = r.data[15:8];
						CMD_IOUT:   nxt_st.miout[pg] = r.data[15:8];
						CMD_TEMP:   nxt_st.mtemp[pg] = r.data[15:8];
						CMD_INPUT:  nxt_st.minp      = r.data[15:8];
						CMD_CML:    nxt_st.mcml      = r.data[15:8];
						CMD_VENDOR: nxt_st.mmfr[pg]  = r.data[15:8];
						default:    nxt_st.cml_inv   = 1'b1;
					endcase
				end
				K_MASKR: begin
					case (r.data[7:0])
						CMD_VOUT:   rd = {8'h00, st_ff.mvout[pg]};
						CMD_IOUT:   rd = {8'h00, st_ff.miout[pg]};
						CMD_TEMP:   rd = {8'h00, st_ff.mtemp[pg]};
						CMD_INPUT:  rd = {8'h00, st_ff.minp};
						CMD_CML:    rd = {8'h00, st_ff.mcml};
						CMD_VENDOR: rd = {8'h00, st_ff.mmfr[pg]};
						default:    nxt_st.cml_inv = 1'b1;
					endcase
				end
				default: rd = 16'h0000;
			endcase
			nxt_st.rsp = rd;
		end
		if (clr_all) begin
			clr_v  = 8'hFF;
			clr_i  = 8'hFF;
			clr_t  = 8'hFF;
			clr_s  = 8'hFF;
			clr_in = 8'hFF;
		end
		// Set wins over clear, so a lingering condition re-latches at once
		for (int c = 0; c < 2; c++) begin
			cv = {st_ff.in_s2.ch[c].vout, 1'b0};
			ci = {st_ff.in_s2.ch[c].iout_oc, 1'b0, st_ff.in_s2.ch[c].iout_ocw, 5'h00};
			ct = {st_ff.in_s2.ch[c].temp_ot, st_ff.in_s2.ch[c].temp_otw, 1'b0,
				st_ff.in_s2.ch[c].temp_ut, 4'h0};
			if (pg == c[0] || clr_all) begin
				nxt_st.vout[c] = (st_ff.vout[c] & ~clr_v) | cv;
				nxt_st.iout[c] = (st_ff.iout[c] & ~clr_i) | ci;
				nxt_st.temp[c] = (st_ff.temp[c] & ~clr_t) | ct;
				nxt_st.busy[c] = (st_ff.busy[c] & ~clr_s[7]) | st_ff.in_s2.ch[c].busy;
				nxt_st.nota[c] = (st_ff.nota[c] & ~clr_s[0]) | (|sword[c][15:8]);
			end else begin
				nxt_st.vout[c] = st_ff.vout[c] | cv;
				nxt_st.iout[c] = st_ff.iout[c] | ci;
				nxt_st.temp[c] = st_ff.temp[c] | ct;
				nxt_st.busy[c] = st_ff.busy[c] | st_ff.in_s2.ch[c].busy;
				nxt_st.nota[c] = st_ff.nota[c] | (|sword[c][15:8]);
			end
		end
		nxt_st.inp = ((st_ff.inp & ~clr_in) | {st_ff.in_s2.in_ov, 1'b0, st_ff.in_s2.in_uvw,
			3'b000, st_ff.in_s2.in_ocw, 1'b0}) & INP_LATCH_BITS;
		// Clear-all forces the line released for one cycle
		nxt_st.alert = alert_any & ~clr_all;
	end

	// Core state register
	always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st_ff <= CORE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Link next state: accept one request, wait for core acknowledge
	always_comb begin
		nxt_lk           = lk_ff;
		nxt_lk.ack_s1    = st_ff.ack_tgl;
		nxt_lk.ack_s2    = lk_ff.ack_s1;
		nxt_lk.ack_s3    = lk_ff.ack_s2;
		nxt_lk.rsp_valid = 1'b0;
		// Core response word is stable once the toggle is seen here
		if (lk_ff.ack_s2 != lk_ff.ack_s3) begin
			nxt_lk.rsp_valid = 1'b1;
			nxt_lk.rsp       = st_ff.rsp;
			nxt_lk.busy      = 1'b0;
		end else if (CMD_VALID_I && !lk_ff.busy) begin
			nxt_lk.req     = CMD_I;
			nxt_lk.req_tgl = ~lk_ff.req_tgl;
			nxt_lk.busy    = 1'b1;
		end
	end

	// Link state register
	always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			lk_ff <= LINK_RST;
		end else begin
			lk_ff <= nxt_lk;
		end
	end

	// Outputs
	assign CMD_READY_O   = ~lk_ff.busy;
	assign RSP_VALID_O   = lk_ff.rsp_valid;
	assign RSP_DATA_O    = lk_ff.rsp;
	assign ALERT_N_O     = ~st_ff.alert;
	assign CML_INVALID_O = st_ff.cml_inv;
	assign CLEAR_PEAKS_O = st_ff.peak_clr;

	// Checks
	property p_mask_latch;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(st_ff.in_s2.ch[0].iout_oc && st_ff.miout[0][7]) |=> st_ff.iout[0][7];
	endproperty
	a_mask_latch: assert property (p_mask_latch) else $error("masked bit not latched");

	property p_alert_quiet;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		!alert_any ##1 !alert_any |-> ALERT_N_O;
	endproperty
	a_alert_quiet: assert property (p_alert_quiet) else $error("alert low without source");

	property p_bad_mask;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(go && lk_ff.req.kind == K_MASKW && lk_ff.req.data[7:0] == CMD_SUM_WORD)
			|=> CML_INVALID_O && $stable(st_ff.mvout);
	endproperty
	a_bad_mask: assert property (p_bad_mask) else $error("summary mask accepted");

	property p_mask_hold;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		!(go && lk_ff.req.kind == K_MASKW) |=> $stable(st_ff.mmfr) && $stable(st_ff.mcml);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask changed unasked");

	property p_peaks;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(go && lk_ff.req.kind == K_SEND && lk_ff.req.cmd == CMD_CLEAR_PEAKS)
			|=> CLEAR_PEAKS_O ##1 !CLEAR_PEAKS_O;
	endproperty
	a_peaks: assert property (p_peaks) else $error("peak clear missing");

	property p_byte_is_low;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(go && lk_ff.req.kind == K_READ && lk_ff.req.cmd == CMD_SUM_BYTE)
			|=> st_ff.rsp == {8'h00, $past(sword[0][7:0])} || $past(lk_ff.req.page);
	endproperty
	a_byte_is_low: assert property (p_byte_is_low) else $error("byte differs from word");

	property p_nota;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(|sword[1][15:8]) |=> st_ff.nota[1];
	endproperty
	a_nota: assert property (p_nota) else $error("other-fault bit missing");

	property p_in_off_live;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		st_ff.in_s2.in_off |-> inp_view[INP_OFF_BIT] && !st_ff.inp[INP_OFF_BIT];
	endproperty
	a_in_off_live: assert property (p_in_off_live) else $error("input off bit latched");

	property p_clear_all;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(go && lk_ff.req.kind == K_SEND && lk_ff.req.cmd == CMD_CLEAR_FAULTS && !any_cond)
			##1 !any_cond |-> ##[1:CLR_BOUND] ALERT_N_O;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("alert not released");

	property p_w1c_vout;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(go && lk_ff.req.kind == K_WRITE && lk_ff.req.cmd == CMD_VOUT &&
			!lk_ff.req.page && lk_ff.req.data[5] && !st_ff.in_s2.ch[0].vout[4])
			|=> !st_ff.vout[0][5];
	endproperty
	a_w1c_vout: assert property (p_w1c_vout) else $error("write one did not clear");

endmodule
`default_nettype wire

// file: fsam_host.sv
// Host model for the link side: one decoded request at a time, answer collected
`default_nettype none
module fsam_host
	import fsam_pkg::*;
(
	// Link clock
	input  wire logic        lclk_i,
	// Request
	output var logic         valid_o,
	output var fsam_req_type req_o,
	// Answer
	input  wire logic        ready_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [15:0] rsp_data_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle at time zero
	initial begin
		valid_o = 1'b0;
		req_o = '0;
	end

	// Change at falling edge, hold until a rising edge takes it with ready high
	task automatic xfer(input fsam_req_type r, output logic [15:0] d, output logic ok);
		int n;
		n = 0;
		@(negedge lclk_i);
		valid_o = 1'b1;
		req_o = r;
		while (ready_i !== 1'b1 && n < 40) begin
			@(negedge lclk_i);
			n++;
		end
		@(posedge lclk_i);
		@(negedge lclk_i);
		valid_o = 1'b0;
		// Released fields flip so a stale copy never passes for a request
		req_o = ~r;
		while (rsp_valid_i !== 1'b1 && n < 80) begin
			@(negedge lclk_i);
			n++;
		end
		d = rsp_data_i;
		ok = n < 80;
	endtask

	// Mask write: target code in byte one, mask in byte two
	task automatic mask_wr(input logic p, input logic [7:0] c, input logic [7:0] m,
		output logic ok);
		logic [15:0] d;
		xfer('{cmd: CMD_ALERT_MASK, kind: K_MASKW, data: {m, c}, page: p}, d, ok);
	endtask

	// Mask read: target code goes out, mask byte comes back in the low byte
	task automatic mask_rd(input logic p, input logic [7:0] c, output logic [7:0] m,
		output logic ok);
		logic [15:0] d;
		xfer('{cmd: CMD_ALERT_MASK, kind: K_MASKR, data: {8'h00, c}, page: p}, d, ok);
		m = d[7:0];
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for the fault status, mask and alert block
`default_nettype none
module tb_top
	import fsam_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] SOFT_RST = 8'hFD;
	logic          ref_clk = 1'b0;
	logic          lclk = 1'b0;
	logic          rst = 1'b1;
	logic          valid;
	logic          ready;
	logic          rsp_valid;
	logic          alert_n;
	logic          cml_inv;
	logic          clr_pk;
	logic [15:0]   rsp_data;
	fsam_req_type  req;
	fsam_cond_type cond;
	fsam_cond_type nc;
	int            n_mismatch = 0;
	int            cmp_count = 0;
	int            n_inv = 0;
	int            n_pk = 0;

	// Core clock 125 MHz
	always #4 ref_clk = ~ref_clk;

	// Link clock 80 ns, offset so its edges never meet core edges
	initial begin
		#13;
		forever #40 lclk = ~lclk;
	end

	fsam_top #(.SOFT_RESET_CODE(SOFT_RST)) dut (
		.REF_CLK_I(ref_clk), .RESET_I(rst), .LINK_CLK_I(lclk), .CMD_VALID_I(valid),
		.CMD_I(req), .CMD_READY_O(ready), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
		.STAT_I(cond), .ALERT_N_O(alert_n), .CML_INVALID_O(cml_inv), .CLEAR_PEAKS_O(clr_pk)
	);
	fsam_host host (.lclk_i(lclk), .valid_o(valid), .req_o(req), .ready_i(ready),
		.rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data));

	// Side-effect pulses counted mid-cycle, away from the launching edge
	always @(negedge ref_clk) begin
		if (cml_inv === 1'b1) n_inv++;
		if (clr_pk === 1'b1) n_pk++;
	end

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic ack(input logic ok);
		check("link answer", {15'h0000, ok}, 16'h0001);
	endtask

	task automatic go(input fsam_kind_type k, input logic [7:0] c, input logic p,
		input logic [15:0] w, output logic [15:0] d);
		logic ok;
		host.xfer('{cmd: c, kind: k, data: w, page: p}, d, ok);
		ack(ok);
	endtask

	task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] w);
		logic [15:0] d;
		go(K_WRITE, c, p, w, d);
	endtask

	task automatic snd(input logic [7:0] c);
		logic [15:0] d;
		go(K_SEND, c, 1'b0, 16'h0000, d);
	endtask

	task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e);
		logic [15:0] d;
		go(K_READ, c, p, 16'h0000, d);
		check($sformatf("read %h page %0d", c, p), d, e);
	endtask

	task automatic mwr(input logic p, input logic [7:0] c, input logic [7:0] m);
		logic ok;
		host.mask_wr(p, c, m, ok);
		ack(ok);
	endtask

	task automatic mrd(input logic p, input logic [7:0] c, input logic [7:0] e);
		logic ok;
		logic [7:0] m;
		host.mask_rd(p, c, m, ok);
		ack(ok);
		check($sformatf("mask %h page %0d", c, p), {8'h00, m}, {8'h00, e});
	endtask

	task automatic alc(input logic e);
		check("alert line", {15'h0000, alert_n}, {15'h0000, e});
	endtask

	// Conditions change at a falling edge, then pass sync, latch and alert stages
	task automatic settle;
		@(negedge ref_clk);
		cond = nc;
		repeat (10) @(negedge ref_clk);
	endtask

	// Reset: alert idle, masks at defaults
	task automatic t_reset;
		logic [7:0] codes [5] = '{CMD_VOUT, CMD_IOUT, CMD_TEMP, CMD_CML, CMD_INPUT};
		alc(1'b1);
		for (int i = 0; i < 5; i++) begin
			mrd(1'b0, codes[i], 8'h00);
		end
		mrd(1'b0, CMD_VENDOR, 8'h11);
		mrd(1'b1, CMD_VENDOR, 8'h11);
	endtask

	// Voltage flags: latch, page copy, summary, clear by one, set wins
	task automatic t_vout;
		snd(CMD_CLEAR_FAULTS);
		nc.ch[0].vout[6] = 1'b1;
		settle();
		alc(1'b0);
		rd(CMD_VOUT, 1'b0, 16'h0080);
		rd(CMD_VOUT, 1'b1, 16'h0000);
		rd(CMD_SUM_BYTE, 1'b0, 16'h0021);
		rd(CMD_SUM_WORD, 1'b0, 16'h8021);
		wr(CMD_VOUT, 1'b0, 16'h0080);
		rd(CMD_VOUT, 1'b0, 16'h0080);
		nc.ch[0].vout[6] = 1'b0;
		settle();
		wr(CMD_VOUT, 1'b0, 16'h0000);
		rd(CMD_VOUT, 1'b0, 16'h0080);
		wr(CMD_VOUT, 1'b0, 16'h0080);
		rd(CMD_VOUT, 1'b0, 16'h0000);
		wr(CMD_SUM_BYTE, 1'b0, 16'h0001);
		rd(CMD_SUM_BYTE, 1'b0, 16'h0000);
		alc(1'b1);
		for (int i = 0; i < 6; i++) begin
			nc.ch[0].vout[i] = 1'b1;
			settle();
			nc.ch[0].vout[i] = 1'b0;
			settle();
			rd(CMD_VOUT, 1'b0, 16'h0002 << i);
			wr(CMD_VOUT, 1'b0, 16'h00FE);
		end
	endtask

	// Masks: masked bit latches silently; unsupported targets refused
	task automatic t_mask;
		logic [7:0] bad [4] = '{CMD_SUM_BYTE, CMD_SUM_WORD, 8'hEF, 8'hE5};
		int n0;
		snd(CMD_CLEAR_FAULTS);
		mwr(1'b0, CMD_IOUT, 8'h80);
		mrd(1'b0, CMD_IOUT, 8'h80);
		mrd(1'b1, CMD_IOUT, 8'h00);
		nc.ch[0].iout_oc = 1'b1;
		settle();
		rd(CMD_IOUT, 1'b0, 16'h0080);
		alc(1'b1);
		nc.ch[0].iout_ocw = 1'b1;
		settle();
		rd(CMD_IOUT, 1'b0, 16'h00A0);
		alc(1'b0);
		nc.ch[0].iout_oc = 1'b0;
		nc.ch[0].iout_ocw = 1'b0;
		settle();
		snd(CMD_CLEAR_FAULTS);
		alc(1'b1);
		rd(CMD_IOUT, 1'b0, 16'h0000);
		mwr(1'b0, CMD_IOUT, 8'h00);
		n0 = n_inv;
		for (int i = 0; i < 4; i++) begin
			mwr(1'b0, bad[i], 8'hFF);
			check("refused mask", 16'(n_inv - n0), 16'(i + 1));
		end
		mrd(1'b0, CMD_SUM_BYTE, 8'h00);
		check("refused read", 16'(n_inv - n0), 16'd5);
		mrd(1'b0, CMD_VOUT, 8'h00);
		check("good mask", 16'(n_inv - n0), 16'd5);
	endtask

	// Input flags: live off bit never alerts, others latch and alert
	task automatic t_input;
		snd(CMD_CLEAR_FAULTS);
		nc.in_off = 1'b1;
		settle();
		rd(CMD_INPUT, 1'b0, 16'h0008);
		alc(1'b1);
		nc.in_off = 1'b0;
		settle();
		rd(CMD_INPUT, 1'b0, 16'h0000);
		{nc.in_ov, nc.in_uvw, nc.in_ocw} = 3'b111;
		settle();
		{nc.in_ov, nc.in_uvw, nc.in_ocw} = 3'b000;
		settle();
		rd(CMD_INPUT, 1'b1, 16'h00A2);
		alc(1'b0);
		rd(CMD_SUM_WORD, 1'b0, 16'h2001);
		wr(CMD_INPUT, 1'b0, 16'h00A2);
		rd(CMD_INPUT, 1'b0, 16'h0000);
		alc(1'b1);
	endtask

	// Temperature flags on page one only
	task automatic t_temp;
		snd(CMD_CLEAR_FAULTS);
		{nc.ch[1].temp_ot, nc.ch[1].temp_otw, nc.ch[1].temp_ut} = 3'b111;
		settle();
		alc(1'b0);
		{nc.ch[1].temp_ot, nc.ch[1].temp_otw, nc.ch[1].temp_ut} = 3'b000;
		settle();
		rd(CMD_TEMP, 1'b1, 16'h00D0);
		rd(CMD_TEMP, 1'b0, 16'h0000);
		rd(CMD_SUM_BYTE, 1'b1, 16'h0004);
		snd(CMD_CLEAR_FAULTS);
		rd(CMD_TEMP, 1'b1, 16'h0000);
	endtask

	// Off, not-good, busy and vendor summary bits
	task automatic t_sum;
		snd(CMD_CLEAR_FAULTS);
		nc.ch[0].out_on = 1'b0;
		nc.ch[0].pgood = 1'b0;
		settle();
		rd(CMD_SUM_WORD, 1'b0, 16'h0841);
		nc.ch[0].out_on = 1'b1;
		nc.ch[0].pgood = 1'b1;
		nc.ch[0].busy = 1'b1;
		settle();
		nc.ch[0].busy = 1'b0;
		settle();
		wr(CMD_SUM_BYTE, 1'b0, 16'h0001);
		rd(CMD_SUM_BYTE, 1'b0, 16'h0080);
		alc(1'b0);
		wr(CMD_SUM_BYTE, 1'b0, 16'h0080);
		rd(CMD_SUM_BYTE, 1'b0, 16'h0000);
		nc.ch[0].vendor = 8'h11;
		settle();
		alc(1'b1);
		rd(CMD_SUM_WORD, 1'b0, 16'h1001);
		nc.ch[0].vendor = 8'h04;
		settle();
		alc(1'b0);
		mwr(1'b0, CMD_VENDOR, 8'h15);
		alc(1'b1);
		mwr(1'b0, CMD_VENDOR, MASK_RST_VENDOR);
		alc(1'b0);
	endtask

	// Both peak-clearing commands pulse the clear output once
	task automatic t_peaks;
		int n0;
		n0 = n_pk;
		snd(CMD_CLEAR_PEAKS);
		check("peak clear", 16'(n_pk - n0), 16'd1);
		snd(SOFT_RST);
		check("soft reset", 16'(n_pk - n0), 16'd2);
	endtask

	// Watchdog well past the expected run length
	initial begin
		#500000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		nc = '0;
		nc.ch[0].out_on = 1'b1;
		nc.ch[1].out_on = 1'b1;
		nc.ch[0].pgood = 1'b1;
		nc.ch[1].pgood = 1'b1;
		cond = nc;
		repeat (5) @(negedge ref_clk);
		// Link side also needs two of its own edges inside reset
		repeat (2) @(posedge lclk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_vout();
		t_mask();
		t_input();
		t_temp();
		t_sum();
		t_peaks();
		stop_test();
	end
endmodule
`default_nettype wire
